//--- pkg/cmx_pkg.sv
package cmx_pkg;
    // opcode patterns
    localparam logic [15:0] OP_IDLE     = 16'h0000;
    localparam logic [15:0] OP_POP      = 16'h0006;
    localparam logic [15:0] OP_PUSH     = 16'h0005;
    localparam logic [15:0] OP_SWRESET  = 16'h00ff;
    localparam logic [7:0]  OPH_MULLIT  = 8'h0d;
    localparam logic [6:0]  OPH_MULREG  = 7'h01;
    localparam logic [6:0]  OPH_NEGREG  = 7'h36;
    localparam logic [4:0]  OPH_RELATIVE_CALL_OP   = 5'h1b;
    localparam logic [3:0]  OPN_IDLE2   = 4'hf;
    // addressing
    localparam logic [7:0]  ILO_LIMIT   = 8'h5f;
    localparam logic [7:0]  ACC_SPLIT   = 8'h60;
    localparam logic [3:0]  ACC_HI_BANK = 4'hf;
    localparam int          STACK_DEPTH = 31;
    localparam int          SP_W        = 5;
    // status bit positions
    localparam int          ST_C  = 0;
    localparam int          ST_DC = 1;
    localparam int          ST_Z  = 2;
    localparam int          ST_OV = 3;
    localparam int          ST_N  = 4;
    // reset values
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [20:0] RST_PC      = 21'h000000;
    localparam logic [20:0] PC_STEP     = 21'h000002;
    // apb map
    localparam logic [7:0]  A_CTRL   = 8'h00;
    localparam logic [7:0]  A_INSTR  = 8'h04;
    localparam logic [7:0]  A_WREG   = 8'h08;
    localparam logic [7:0]  A_BANK   = 8'h0c;
    localparam logic [7:0]  A_FSR2   = 8'h10;
    localparam logic [7:0]  A_PROD   = 8'h14;
    localparam logic [7:0]  A_STATUS = 8'h18;
    localparam logic [7:0]  A_PC     = 8'h1c;
    localparam logic [7:0]  A_HEAD   = 8'h20;
    localparam logic [7:0]  A_MADDR  = 8'h24;
    localparam logic [7:0]  A_MDATA  = 8'h28;
    localparam logic [7:0]  A_SP     = 8'h2c;
    localparam int          CTRL_XINST = 0;
endpackage

//--- pkg/cmx_mem_if.sv
`timescale 1ns/1ps
interface cmx_mem_if;
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic [7:0]  rdata;
    modport core (output addr, output wdata, output we, input rdata);
    modport mem  (input addr, input wdata, input we, output rdata);
endinterface

//--- hw/cmx_data_ram.sv
`timescale 1ns/1ps
module cmx_data_ram
    import cmx_pkg::*;
(
    input  wire logic pclk,
    cmx_mem_if.mem    port_a,
    input  wire logic [11:0] b_addr,
    input  wire logic        b_we,
    input  wire logic [7:0]  b_wdata,
    output      logic [7:0]  b_rdata
);
    // =========================================================
    // data memory, async read, two write ports (a wins)
    logic [7:0] ram [0:4095];

    assign port_a.rdata = ram[port_a.addr];
    assign b_rdata      = ram[b_addr];

    always_ff @(posedge pclk) begin
        if (port_a.we) begin
            ram[port_a.addr] <= port_a.wdata;
        end else if (b_we) begin
            ram[b_addr] <= b_wdata;
        end
    end
endmodule

//--- hw/cmx_core.sv
`timescale 1ns/1ps
// Behaviour
// - multiply-literal: accumulator times low instruction byte, unsigned
// - 16-bit product: high byte and low byte to product pair
// - multiply-register: accumulator times file register, sources untouched
// - multiplies change no flag and leave the accumulator alone
// - zero product unflagged; no carry or overflow logic
// - access bit 0 uses access bank, 1 uses bank select
// - a=0, extended set on, f<=95: indexed literal offset
// - negate writes inverted value plus one back to same byte
// - pop discards head in one cycle, previous entry becomes head
// - push saves pc+2, older head moves down, one cycle
// - relative call: push pc+2, pc becomes pc+2+2n, two cycles
// - software reset restores master-clear registers except xinst, maddr and instr
module cmx_core
    import cmx_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output      logic [31:0] prdata,
    output      logic        pready,
    output      logic        pslverr,
    output      logic        busy
);
    // =========================================================
    // state
    typedef enum logic [1:0] {CMX_IDLE, CMX_EXEC, CMX_FLUSH} cmx_st_e;

    cmx_st_e     st, next_st;
    logic [15:0] instr, next_instr;
    logic [7:0]  wreg, next_wreg;
    logic [7:0]  bank_select_reg, next_bank_select_reg;
    logic [11:0] fsr2, next_fsr2;
    logic [7:0]  product_high_byte, next_product_high_byte;
    logic [7:0]  product_low_byte, next_product_low_byte;
    logic [7:0]  status, next_status;
    logic [20:0] pc, next_pc;
    logic [SP_W-1:0] sp, next_sp;
    logic        xinst, next_xinst;
    logic [11:0] maddr, next_maddr;
    logic [31:0] next_prdata;
    logic        next_pready, next_pslverr, next_busy;
    logic [20:0] stack [1:STACK_DEPTH];
    logic [20:0] next_head;
    logic        head_we;
    logic [SP_W-1:0] head_idx;

    cmx_mem_if   mif();
    logic [7:0]  b_rdata;
    logic        b_we;

    cmx_data_ram u_ram (
        .pclk    (pclk),
        .port_a  (mif.mem),
        .b_addr  (maddr),
        .b_we    (b_we),
        .b_wdata (pwdata[7:0]),
        .b_rdata (b_rdata)
    );

    // =========================================================
    // operand address
    logic       acc_bit;
    logic [7:0] f_field;
    logic [11:0] eff_addr;

    always_comb begin
        acc_bit = instr[8];
        f_field = instr[7:0];
        if (acc_bit) begin
            eff_addr = {bank_select_reg[3:0], f_field};
        end else if (xinst && (f_field <= ILO_LIMIT)) begin
            eff_addr = fsr2 + {4'h0, f_field};
        end else if (f_field >= ACC_SPLIT) begin
            eff_addr = {ACC_HI_BANK, f_field};
        end else begin
            eff_addr = {4'h0, f_field};
        end
    end

    // =========================================================
    // decode
    logic is_mullit, is_mulreg, is_neg, is_pop, is_push;
    logic is_relative_call_op, is_swreset;

    always_comb begin
        is_mullit  = instr[15:8] == OPH_MULLIT;
        is_mulreg  = instr[15:9] == OPH_MULREG;
        is_neg     = instr[15:9] == OPH_NEGREG;
        is_pop     = instr == OP_POP;
        is_push    = instr == OP_PUSH;
        is_relative_call_op   = instr[15:11] == OPH_RELATIVE_CALL_OP;
        is_swreset = instr == OP_SWRESET;
    end

    // =========================================================
    // datapath
    logic [15:0] prod;
    logic [7:0]  mul_b, fval, neg_res;
    logic [8:0]  neg_sum;
    logic [4:0]  neg_lo;
    logic [20:0] pc2, rel_off;

    always_comb begin
        fval    = mif.rdata;
        mul_b   = is_mullit ? instr[7:0] : fval;
        prod    = 16'(mul_b) * 16'(wreg);
        neg_sum = {1'b0, ~fval} + 9'h001;
        neg_lo  = {1'b0, ~fval[3:0]} + 5'h01;
        neg_res = neg_sum[7:0];
        pc2     = pc + PC_STEP;
        rel_off = {{9{instr[10]}}, instr[10:0], 1'b0};
        head_idx = (sp == '0) ? SP_W'(1) : sp;
        mif.addr  = eff_addr;
        mif.wdata = neg_res;
        mif.we    = (st == CMX_EXEC) && is_neg;
    end

    // =========================================================
    // next state
    always_comb begin
        next_st = st;
        next_instr = instr;
        next_wreg = wreg;
        next_bank_select_reg = bank_select_reg;
        next_fsr2 = fsr2;
        next_product_high_byte = product_high_byte;
        next_product_low_byte = product_low_byte;
        next_status = status;
        next_pc = pc;
        next_sp = sp;
        next_xinst = xinst;
        next_maddr = maddr;
        next_head = pc2;
        head_we = 1'b0;
        next_busy = 1'b0;
        b_we = 1'b0;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        next_prdata = prdata;

        unique case (st)
            CMX_IDLE: begin
            end
            CMX_EXEC: begin
                next_st = CMX_IDLE;
                next_pc = pc2;
                if (is_mullit || is_mulreg) begin
                    // wreg and status deliberately untouched
                    next_product_high_byte = prod[15:8];
                    next_product_low_byte  = prod[7:0];
                end else if (is_neg) begin
                    next_status[ST_N]  = neg_res[7];
                    next_status[ST_Z]  = neg_res == 8'h00;
                    next_status[ST_C]  = neg_sum[8];
                    next_status[ST_DC] = neg_lo[4];
                    next_status[ST_OV] = fval == 8'h80;
                end else if (is_pop) begin
                    if (sp != '0) begin
                        next_sp = sp - SP_W'(1);
                    end
                end else if (is_push || is_relative_call_op) begin
                    // full stack overwrites its top entry
                    if (sp != SP_W'(STACK_DEPTH)) begin
                        next_sp = sp + SP_W'(1);
                    end
                    head_we = 1'b1;
                    if (is_relative_call_op) begin
                        next_pc = pc2 + rel_off;
                        next_st = CMX_FLUSH;
                    end
                end else if (is_swreset) begin
                    next_wreg = RST_BYTE;
                    next_bank_select_reg = RST_BYTE;
                    next_fsr2 = '0;
                    next_product_high_byte = RST_BYTE;
                    next_product_low_byte = RST_BYTE;
                    next_status = RST_BYTE;
                    next_pc = RST_PC;
                    next_sp = '0;
                end
                // idle words and unknown words: only pc moves
            end
            CMX_FLUSH: begin
                next_st = CMX_IDLE;
            end
            default: next_st = CMX_IDLE;
        endcase

        next_busy = next_st != CMX_IDLE;

        if (psel && !penable) begin
            next_pready = 1'b1;
            if (pwrite) begin
                unique case (paddr)
                    A_CTRL:  next_xinst = pwdata[CTRL_XINST];
                    A_INSTR: begin
                        if (st == CMX_IDLE) begin
                            next_instr = pwdata[15:0];
                            next_st = CMX_EXEC;
                            next_busy = 1'b1;
                        end else begin
                            next_pslverr = 1'b1;
                        end
                    end
                    A_WREG:  next_wreg = pwdata[7:0];
                    A_BANK:  next_bank_select_reg = {4'h0, pwdata[3:0]};
                    A_FSR2:  next_fsr2 = pwdata[11:0];
                    A_PC:    next_pc = {pwdata[20:1], 1'b0};
                    A_MADDR: next_maddr = pwdata[11:0];
                    A_MDATA: b_we = 1'b1;
                    default: next_pslverr = !(paddr == A_PROD
                        || paddr == A_STATUS || paddr == A_HEAD
                        || paddr == A_SP);
                endcase
            end else begin
                next_prdata = 32'h00000000;
                unique case (paddr)
                    A_CTRL:   next_prdata[0] = xinst;
                    A_INSTR:  next_prdata[15:0] = instr;
                    A_WREG:   next_prdata[7:0] = wreg;
                    A_BANK:   next_prdata[7:0] = bank_select_reg;
                    A_FSR2:   next_prdata[11:0] = fsr2;
                    A_PROD:   next_prdata[15:0] =
                        {product_high_byte, product_low_byte};
                    A_STATUS: next_prdata[7:0] = status;
                    A_PC:     next_prdata[20:0] = pc;
                    A_HEAD:   next_prdata[20:0] =
                        (sp == '0) ? 21'h000000 : stack[head_idx];
                    A_MADDR:  next_prdata[11:0] = maddr;
                    A_MDATA:  next_prdata[7:0] = b_rdata;
                    A_SP:     next_prdata[SP_W-1:0] = sp;
                    default:  next_pslverr = 1'b1;
                endcase
            end
        end
    end

    // =========================================================
    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= CMX_IDLE;
            instr <= OP_IDLE;
            wreg <= RST_BYTE;
            bank_select_reg <= RST_BYTE;
            fsr2 <= '0;
            product_high_byte <= RST_BYTE;
            product_low_byte <= RST_BYTE;
            status <= RST_BYTE;
            pc <= RST_PC;
            sp <= '0;
            xinst <= 1'b0;
            maddr <= '0;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            busy <= 1'b0;
        end else begin
            st <= next_st;
            instr <= next_instr;
            wreg <= next_wreg;
            bank_select_reg <= next_bank_select_reg;
            fsr2 <= next_fsr2;
            product_high_byte <= next_product_high_byte;
            product_low_byte <= next_product_low_byte;
            status <= next_status;
            pc <= next_pc;
            sp <= next_sp;
            xinst <= next_xinst;
            maddr <= next_maddr;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            busy <= next_busy;
        end
    end

    // stack storage has no reset; sp marks valid entries
    always_ff @(posedge pclk) begin
        if (head_we) begin
            stack[next_sp] <= next_head;
        end
    end
endmodule

//--- verif/cmx_core_monitor.sv
`timescale 1ns/1ps
module cmx_core_monitor
    import cmx_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        busy
);
    logic setup;
    logic instr;
    assign setup = psel && !penable;
    assign instr = setup && pwrite && paddr == A_INSTR;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================
    // bus answer and instruction timing
    answer_next_a: assert property (setup |=> pready)
        else $error("no answer one cycle after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    busy_start_a: assert property (instr && !busy |=> busy)
        else $error("instruction write did not start execution");
    busy_short_a: assert property (busy |-> ##[1:2] !busy)
        else $error("instruction ran longer than two cycles");
    busy_refuse_a: assert property (instr && busy |=> pslverr)
        else $error("instruction write while busy not refused");
    // reads of holes return zero so software never sees stale data
    unmapped_err_a: assert property (setup && !pwrite && paddr > A_SP
        |=> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    mapped_ok_a: assert property (setup && paddr <= A_SP
        && paddr[1:0] == 2'b00 && !(pwrite && paddr == A_INSTR)
        |=> !pslverr)
        else $error("mapped access refused");
endmodule

//--- verif/cmx_core_tb.sv
`timescale 1ns/1ps
module cmx_core_tb;
    import cmx_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        busy;
    logic [41:0] q[$];
    logic [41:0] ent;
    logic [31:0] seed = 32'd69148;
    logic [20:0] pc = RST_PC;
    logic [20:0] hd;
    logic [7:0]  w, k, f, r, st;
    logic [21:0] e;
    logic [7:0]  nv [4] = '{8'hff, 8'h3a, 8'h00, 8'h80};
    logic [21:0] mt [5] = '{{2'b10, 8'h34, 12'h234}, {2'b00, 8'h20, 12'h020},
        {2'b00, 8'h70, 12'hf70}, {2'b01, 8'h20, 12'h320},
        {2'b01, 8'h60, 12'hf60}};
    logic [7:0]  zr [7] = '{A_WREG, A_BANK, A_FSR2, A_PROD, A_STATUS, A_PC,
        A_SP};
    int          n_errors = 0;
    int          n_tests = 0;
    int          i;

    always #12.5 pclk = ~pclk;

    cmx_core uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [31:0] s, input logic [31:0] x,
                       input logic [7:0] a);
        n_tests++;
        if (s !== x) begin
            n_errors++;
            $display("wrong value reg %h: expected %h, seen %h", a, x, s);
        end
    endtask

    task automatic test_done;
        $display("checks %0d, errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ==========================================
    // result watcher: oldest note against each answer
    always @(posedge pclk) begin
        if (psel && penable && pready) begin
            ent = q.pop_front();
            chk({31'h0, pslverr}, {31'h0, ent[41]}, ent[7:0]);
            if (ent[40]) begin
                chk(prdata, ent[39:8], ent[7:0]);
            end
        end
    end

    // ==========================================
    // bus master; rel=0 keeps psel up for a back-to-back transfer
    task automatic acc(input logic wr, input logic [7:0] a,
        input logic [31:0] d, input logic ee, input logic cd, input logic rel);
        int n;
        n = 0;
        q.push_back({ee, cd, d, a});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (!pready && n < 20);
        if (!pready) begin
            n_errors++;
            test_done();
        end
        if (rel) begin
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d, 1'b0, 1'b0, 1'b1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        acc(1'b0, a, x, 1'b0, 1'b1, 1'b1);
    endtask

    task automatic idle_wait;
        int n;
        n = 0;
        while (busy && n < 10) begin
            @(posedge pclk);
            n++;
        end
        if (busy) begin
            n_errors++;
            test_done();
        end
    endtask

    task automatic run(input logic [15:0] op);
        wr(A_INSTR, {16'h0, op});
        idle_wait();
        pc = pc + PC_STEP;
    endtask

    task automatic mset(input logic [11:0] a, input logic [7:0] d);
        wr(A_MADDR, {20'h0, a});
        wr(A_MDATA, {24'h0, d});
    endtask

    task automatic mget(input logic [11:0] a, input logic [7:0] x);
        wr(A_MADDR, {20'h0, a});
        rd(A_MDATA, {24'h0, x});
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(A_SP, 32'h0);
        wr(A_BANK, 32'h2);
        for (i = 0; i < 4; i++) begin
            f = nv[i];
            r = ~f + 8'h01;
            mset(12'h2f0 + 12'(i), f);
            run({OPH_NEGREG, 1'b1, 8'hf0 + 8'(i)});
            mget(12'h2f0 + 12'(i), r);
            st = {3'b0, r[7], f == 8'h80, r == 8'h0, f[3:0] == 4'h0,
                f == 8'h0};
            rd(A_STATUS, {24'h0, st});
        end
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            w = seed[7:0];
            k = (i == 0) ? 8'h00 : seed[15:8];
            wr(A_WREG, {24'h0, w});
            run({OPH_MULLIT, k});
            rd(A_PROD, 32'(w) * 32'(k));
            rd(A_WREG, {24'h0, w});
            rd(A_STATUS, {24'h0, st});
        end
        wr(A_FSR2, 32'h300);
        for (i = 0; i < 5; i++) begin
            e = mt[i];
            seed = lfsr(seed);
            wr(A_CTRL, {31'h0, e[20]});
            mset(e[11:0], seed[23:16]);
            wr(A_WREG, {24'h0, seed[7:0]});
            run({OPH_MULREG, e[21], e[19:12]});
            rd(A_PROD, 32'(seed[7:0]) * 32'(seed[23:16]));
            mget(e[11:0], seed[23:16]);
            rd(A_WREG, {24'h0, seed[7:0]});
        end
        run(OP_PUSH);
        hd = pc;
        rd(A_HEAD, {11'h0, pc});
        run(OP_PUSH);
        rd(A_HEAD, {11'h0, pc});
        run(OP_POP);
        rd(A_HEAD, {11'h0, hd});
        rd(A_SP, 32'h1);
        // second instruction lands in the call's second cycle
        hd = pc + PC_STEP;
        acc(1'b1, A_INSTR, {16'h0, OPH_RELATIVE_CALL_OP, 11'h3ff}, 1'b0, 1'b0, 1'b0);
        acc(1'b1, A_INSTR, {16'h0, OP_PUSH}, 1'b1, 1'b0, 1'b1);
        idle_wait();
        pc = pc + 21'd2048;
        rd(A_PC, {11'h0, pc});
        rd(A_HEAD, {11'h0, hd});
        hd = pc + PC_STEP;
        run({OPH_RELATIVE_CALL_OP, 11'h400});
        pc = pc - 21'd2048;
        rd(A_PC, {11'h0, pc});
        rd(A_HEAD, {11'h0, hd});
        rd(A_SP, 32'h3);
        wr(A_WREG, 32'h5a);
        run(OP_IDLE);
        run(16'hf123);
        rd(A_PC, {11'h0, pc});
        rd(A_WREG, 32'h5a);
        rd(A_SP, 32'h3);
        run(OP_SWRESET);
        // read-only words ignore writes without an error
        wr(A_PROD, 32'h0000ffff);
        wr(A_SP, 32'h00000005);
        for (i = 0; i < 7; i++) begin
            rd(zr[i], 32'h0);
        end
        rd(A_CTRL, 32'h1);
        acc(1'b0, 8'h40, 32'h0, 1'b1, 1'b1, 1'b1);
        test_done();
    end
endmodule

bind cmx_core cmx_core_monitor mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busy(busy));
